// *** rcp_core.v ***
// Core of a 32-bit RISC processor executing 16-bit instructions, one basic instruction per clock.
`timescale 1ns/100ps
`include "rcp_core_regs.vh"

// Notes on behaviour
// - Every instruction is exactly one 16-bit code word.
// - Basic instructions complete one per core clock cycle.
// - Arithmetic and logic are 32-bit; memory accesses are byte, word or longword.
// - Loaded bytes and words are sign-extended to 32 bits.
// - Arithmetic immediates are sign-extended, logical immediates zero-extended.
// - Operations use registers only; bit-manipulating logic may work on memory.
// - An unconditional branch executes its delay-slot instruction before jumping.
// - Branch target uses register contents from before the delay-slot instruction.
// - First core generation: multiply 1 to 3 cycles, 42-bit accumulate 2 to 3.
// - Later generations: multiply 1 to 2 cycles, 64-bit accumulate 2 to 3.
// - Later generations: 32x32 multiply, with or without accumulate, 2 to 4 cycles.
// - Compares write their outcome into the single compare flag.
// - Conditional branches depend only on the compare flag, set or clear.
// - Register add, including immediate add, leaves the compare flag unchanged.
// - The 8-bit immediate comes from the instruction word itself.
// - Word and longword immediates are loaded PC-relative from a literal table.
// - Absolute addresses are loaded PC-relative, then used register-indirect.
// - Wide displacements are loaded PC-relative, then used indexed register-indirect.

module rcp_core #(
    parameter LATER_GEN = 1                 // 0 selects the first core generation
) (
    input  wire        clk_sys,             // Core clock
    input  wire        arst_n,              // Asynchronous reset, active low
    output wire [31:0] imem_addr,           // Instruction fetch address
    input  wire [15:0] imem_rdata,          // Instruction word at imem_addr
    output reg  [31:0] dmem_addr,           // Data access address
    output reg         dmem_re,             // Data read strobe
    output reg         dmem_we,             // Data write strobe
    output reg  [1:0]  dmem_size,           // Data access size
    output reg  [31:0] dmem_wdata,          // Write data, right-justified
    input  wire [31:0] dmem_rdata,          // Read data, right-justified
    output wire        cmp_flag,            // Compare flag of the status register
    output reg         instr_done           // Pulse when an instruction completes
);

    reg [31:0] rf [0:15];
    reg [31:0] pc_r;
    reg [31:0] pc_nxt;
    reg        t_r;
    reg        t_nxt;
    reg        br_pend_r;
    reg        br_pend_nxt;
    reg [31:0] br_tgt_r;
    reg [31:0] br_tgt_nxt;
    reg [31:0] mach_r;
    reg [31:0] mach_nxt;
    reg [31:0] macl_r;
    reg [31:0] macl_nxt;
    reg [1:0]  cnt_r;
    reg [1:0]  cnt_nxt;
    reg [63:0] mres_r;
    reg [63:0] mres_nxt;
    reg        mboth_r;
    reg        mboth_nxt;
    reg        rmw_r;
    reg        rmw_nxt;
    reg [7:0]  rmw_data_r;
    reg [7:0]  rmw_data_nxt;
    reg        wr_en;
    reg [3:0]  wr_idx;
    reg [31:0] wr_val;
    reg [63:0] prod;

    wire [15:0] ir   = imem_rdata;
    wire [3:0]  op   = ir[15:12];
    wire [3:0]  rn   = ir[11:8];
    wire [3:0]  rm   = ir[7:4];
    wire [3:0]  sub  = ir[3:0];
    wire [7:0]  imm8 = ir[7:0];
    wire [31:0] vn   = rf[rn];
    wire [31:0] vm   = rf[rm];
    wire [31:0] v0   = rf[0];

    assign imem_addr = pc_r;
    assign cmp_flag  = t_r;

    function [31:0] sext8;
        input [7:0] v;
        begin
            sext8 = {{24{v[7]}}, v};
        end
    endfunction

    function [31:0] sext16;
        input [15:0] v;
        begin
            sext16 = {{16{v[15]}}, v};
        end
    endfunction

    // Loaded data widened to a longword by size.
    function [31:0] load_ext;
        input [31:0] v;
        input [1:0]  size;
        begin
            if (size == `RCP_SIZE_BYTE) begin
                load_ext = sext8(v[7:0]);
            end else if (size == `RCP_SIZE_WORD) begin
                load_ext = sext16(v[15:0]);
            end else begin
                load_ext = v;
            end
        end
    endfunction

    // The first generation keeps a 42-bit accumulator; upper bits mirror its sign.
    function [63:0] acc_fix;
        input [63:0] v;
        begin
            if (LATER_GEN != 0) begin
                acc_fix = v;
            end else begin
                acc_fix = {{22{v[41]}}, v[41:0]};
            end
        end
    endfunction

    always @* begin
        pc_nxt       = pc_r + 32'h0000_0002;
        t_nxt        = t_r;
        br_pend_nxt  = br_pend_r;
        br_tgt_nxt   = br_tgt_r;
        mach_nxt     = mach_r;
        macl_nxt     = macl_r;
        cnt_nxt      = cnt_r;
        mres_nxt     = mres_r;
        mboth_nxt    = mboth_r;
        rmw_nxt      = rmw_r;
        rmw_data_nxt = rmw_data_r;
        wr_en        = 1'b0;
        wr_idx       = rn;
        wr_val       = 32'h0000_0000;
        dmem_addr    = 32'h0000_0000;
        dmem_re      = 1'b0;
        dmem_we      = 1'b0;
        dmem_size    = `RCP_SIZE_LONG;
        dmem_wdata   = 32'h0000_0000;
        instr_done   = 1'b1;
        prod         = 64'h0000_0000_0000_0000;
        if (cnt_r > 2'h1) begin
            // Multiplier still working; the instruction is held at the fetch port.
            cnt_nxt    = cnt_r - 2'h1;
            pc_nxt     = pc_r;
            instr_done = 1'b0;
        end else if (cnt_r == 2'h1) begin
            cnt_nxt  = 2'h0;
            macl_nxt = mres_r[31:0];
            if (mboth_r) begin
                mach_nxt = mres_r[63:32];
            end
        end else if (rmw_r) begin
            dmem_addr  = v0;
            dmem_we    = 1'b1;
            dmem_size  = `RCP_SIZE_BYTE;
            dmem_wdata = {24'h00_0000, rmw_data_r};
            rmw_nxt    = 1'b0;
        end else begin
            case (op)
                `RCP_OP_REGREG: begin
                    wr_en = 1'b1;
                    case (sub)
                        `RCP_SUB_ADD:  wr_val = vn + vm;
                        `RCP_SUB_SUB:  wr_val = vn - vm;
                        `RCP_SUB_AND:  wr_val = vn & vm;
                        `RCP_SUB_OR:   wr_val = vn | vm;
                        `RCP_SUB_XOR:  wr_val = vn ^ vm;
                        `RCP_SUB_MOV:  wr_val = vm;
                        `RCP_SUB_STS_MACL: wr_val = macl_r;
                        `RCP_SUB_STS_MACH: wr_val = mach_r;
                        `RCP_SUB_COMPARE_EQUAL: begin
                            wr_en = 1'b0;
                            t_nxt = (vn == vm);
                        end
                        `RCP_SUB_COMPARE_GREATER_EQUAL: begin
                            wr_en = 1'b0;
                            t_nxt = ($signed(vn) >= $signed(vm));
                        end
                        `RCP_SUB_CLRMAC: begin
                            wr_en    = 1'b0;
                            mach_nxt = 32'h0000_0000;
                            macl_nxt = 32'h0000_0000;
                        end
                        `RCP_SUB_MUL_W: begin
                            wr_en      = 1'b0;
                            // Operands are widened first so the product keeps all 32 bits.
                            prod       = {32'h0000_0000, sext16(vn[15:0]) * sext16(vm[15:0])};
                            mres_nxt   = {32'h0000_0000, prod[31:0]};
                            mboth_nxt  = 1'b0;
                            cnt_nxt    = `RCP_LAT_MUL_W - 2'h1;
                            pc_nxt     = pc_r;
                            instr_done = 1'b0;
                        end
                        `RCP_SUB_MAC_W: begin
                            wr_en      = 1'b0;
                            prod       = {32'h0000_0000, sext16(vn[15:0]) * sext16(vm[15:0])};
                            mres_nxt   = acc_fix({mach_r, macl_r} + {{32{prod[31]}}, prod[31:0]});
                            mboth_nxt  = 1'b1;
                            cnt_nxt    = `RCP_LAT_MAC_W - 2'h1;
                            pc_nxt     = pc_r;
                            instr_done = 1'b0;
                        end
                        `RCP_SUB_DMUL_L, `RCP_SUB_MAC_L: begin
                            wr_en = 1'b0;
                            // The first generation has no 32x32 multiplier; these act as no-ops.
                            if (LATER_GEN != 0) begin
                                prod       = $signed(vn) * $signed(vm);
                                mres_nxt   = (sub == `RCP_SUB_MAC_L) ? ({mach_r, macl_r} + prod) : prod;
                                mboth_nxt  = 1'b1;
                                cnt_nxt    = `RCP_LAT_DMUL - 2'h1;
                                pc_nxt     = pc_r;
                                instr_done = 1'b0;
                            end
                        end
                        default: wr_en = 1'b0;
                    endcase
                end
                `RCP_OP_ADDI: begin
                    wr_en  = 1'b1;
                    wr_val = vn + sext8(imm8);
                end
                `RCP_OP_MOVI: begin
                    wr_en  = 1'b1;
                    wr_val = sext8(imm8);
                end
                `RCP_OP_CMPEQI: begin
                    t_nxt = (vn == sext8(imm8));
                end
                `RCP_OP_ANDI: begin
                    wr_en  = 1'b1;
                    wr_val = vn & {24'h00_0000, imm8};
                end
                `RCP_OP_ORI: begin
                    wr_en  = 1'b1;
                    wr_val = vn | {24'h00_0000, imm8};
                end
                `RCP_OP_LOAD: begin
                    // Index form adds R0 to the base, so a wide displacement sits in R0.
                    dmem_addr = sub[2] ? (v0 + vm) : vm;
                    dmem_re   = 1'b1;
                    dmem_size = sub[1:0];
                    wr_en     = 1'b1;
                    wr_val    = load_ext(dmem_rdata, sub[1:0]);
                end
                `RCP_OP_STORE: begin
                    dmem_addr  = sub[2] ? (v0 + vn) : vn;
                    dmem_we    = 1'b1;
                    dmem_size  = sub[1:0];
                    dmem_wdata = vm;
                end
                `RCP_OP_MOVE_WORD: begin
                    dmem_addr = pc_r + 32'h0000_0004 + {23'h00_0000, imm8, 1'b0};
                    dmem_re   = 1'b1;
                    dmem_size = `RCP_SIZE_WORD;
                    wr_en     = 1'b1;
                    wr_val    = load_ext(dmem_rdata, `RCP_SIZE_WORD);
                end
                `RCP_OP_MOVE_LONG: begin
                    dmem_addr = {pc_r[31:2], 2'h0} + 32'h0000_0004 + {22'h00_0000, imm8, 2'h0};
                    dmem_re   = 1'b1;
                    dmem_size = `RCP_SIZE_LONG;
                    wr_en     = 1'b1;
                    wr_val    = dmem_rdata;
                end
                `RCP_OP_BRA: begin
                    // A branch in a delay slot is ignored; the pending target stands.
                    if (!br_pend_r) begin
                        br_pend_nxt = 1'b1;
                        br_tgt_nxt  = pc_r + 32'h0000_0004 + {{19{ir[11]}}, ir[11:0], 1'b0};
                    end
                end
                `RCP_OP_JMP: begin
                    if (!br_pend_r) begin
                        br_pend_nxt = 1'b1;
                        br_tgt_nxt  = vn;
                    end
                end
                `RCP_OP_BR_SET, `RCP_OP_BR_CLEAR: begin
                    if (!br_pend_r && (t_r == (op == `RCP_OP_BR_SET))) begin
                        pc_nxt = pc_r + 32'h0000_0004 + {{23{imm8[7]}}, imm8, 1'b0};
                    end
                end
                `RCP_OP_BITMEM: begin
                    // First cycle reads the byte; the write follows in the next cycle.
                    dmem_addr  = v0;
                    dmem_re    = 1'b1;
                    dmem_size  = `RCP_SIZE_BYTE;
                    rmw_nxt    = 1'b1;
                    pc_nxt     = pc_r;
                    instr_done = 1'b0;
                    if (rn == `RCP_BIT_OR) begin
                        rmw_data_nxt = dmem_rdata[7:0] | imm8;
                    end else begin
                        rmw_data_nxt = dmem_rdata[7:0] & imm8;
                    end
                end
                default: begin
                end
            endcase
        end
        // The slot instruction has completed, so control now moves to the saved target.
        if (br_pend_r && instr_done) begin
            pc_nxt      = br_tgt_r;
            br_pend_nxt = 1'b0;
        end
    end

    // Register file holds data only, so it carries no reset.
    always @(posedge clk_sys) begin
        if (wr_en) begin
            rf[wr_idx] <= wr_val;
        end
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pc_r       <= `RCP_RESET_PC;
            t_r        <= 1'b0;
            br_pend_r  <= 1'b0;
            br_tgt_r   <= 32'h0000_0000;
            mach_r     <= 32'h0000_0000;
            macl_r     <= 32'h0000_0000;
            cnt_r      <= 2'h0;
            mres_r     <= 64'h0000_0000_0000_0000;
            mboth_r    <= 1'b0;
            rmw_r      <= 1'b0;
            rmw_data_r <= 8'h00;
        end else begin
            pc_r       <= pc_nxt;
            t_r        <= t_nxt;
            br_pend_r  <= br_pend_nxt;
            br_tgt_r   <= br_tgt_nxt;
            mach_r     <= mach_nxt;
            macl_r     <= macl_nxt;
            cnt_r      <= cnt_nxt;
            mres_r     <= mres_nxt;
            mboth_r    <= mboth_nxt;
            rmw_r      <= rmw_nxt;
            rmw_data_r <= rmw_data_nxt;
        end
    end

endmodule

// *** rcp_core_regs.vh ***
// Constants for the 16-bit-instruction RISC core: opcodes, sub-operations, sizes and latencies.
`ifndef RCP_CORE_REGS_VH
`define RCP_CORE_REGS_VH

`define RCP_RESET_PC      32'h0000_0000
`define RCP_CLK_PERIOD_NS 10

// Major opcode, instruction bits 15:12.
`define RCP_OP_REGREG     4'h0
`define RCP_OP_ADDI       4'h1
`define RCP_OP_MOVI       4'h2
`define RCP_OP_CMPEQI     4'h3
`define RCP_OP_ANDI       4'h4
`define RCP_OP_ORI        4'h5
`define RCP_OP_LOAD       4'h6
`define RCP_OP_STORE      4'h7
`define RCP_OP_MOVE_WORD  4'h8
`define RCP_OP_MOVE_LONG  4'h9
`define RCP_OP_BRA        4'ha
`define RCP_OP_JMP        4'hb
`define RCP_OP_BR_SET     4'hc
`define RCP_OP_BR_CLEAR   4'hd
`define RCP_OP_BITMEM     4'he

// Register-register sub-operation, instruction bits 3:0.
`define RCP_SUB_ADD       4'h0
`define RCP_SUB_SUB       4'h1
`define RCP_SUB_AND       4'h2
`define RCP_SUB_OR        4'h3
`define RCP_SUB_XOR       4'h4
`define RCP_SUB_MOV       4'h5
`define RCP_SUB_COMPARE_EQUAL    4'h6
`define RCP_SUB_COMPARE_GREATER_EQUAL    4'h7
`define RCP_SUB_MUL_W     4'h8
`define RCP_SUB_MAC_W     4'h9
`define RCP_SUB_DMUL_L    4'ha
`define RCP_SUB_MAC_L     4'hb
`define RCP_SUB_STS_MACL  4'hc
`define RCP_SUB_STS_MACH  4'hd
`define RCP_SUB_CLRMAC    4'he

// Memory access size.
`define RCP_SIZE_BYTE     2'h0
`define RCP_SIZE_WORD     2'h1
`define RCP_SIZE_LONG     2'h2

// Bit-manipulating memory operation, instruction bits 11:8.
`define RCP_BIT_AND       4'h0
`define RCP_BIT_OR        4'h1

// Multiplier latencies in core clock cycles.
`define RCP_LAT_MUL_W     2'h2
`define RCP_LAT_MAC_W     2'h3
`define RCP_LAT_DMUL      2'h3

`endif

// *** rcp_core_chk.sv ***
// Checker for issue rate, branch timing, multiplier latency and compare flag at the core ports.
`timescale 1ns/100ps
module rcp_core_chk #(
    parameter LATER_GEN = 1         // 0 selects the first core generation
) (
    input wire        clk_sys,      // Core clock
    input wire        arst_n,       // Asynchronous reset, active low
    input wire [31:0] imem_addr,    // Fetch address
    input wire [15:0] imem_rdata,   // Fetched instruction
    input wire [31:0] dmem_addr,    // Data address
    input wire        dmem_re,      // Data read strobe
    input wire        dmem_we,      // Data write strobe
    input wire [1:0]  dmem_size,    // Data access size
    input wire [31:0] dmem_wdata,   // Write data
    input wire [31:0] dmem_rdata,   // Read data
    input wire        cmp_flag,     // Compare flag
    input wire        instr_done    // Instruction completes
);
    wire [3:0]  op       = imem_rdata[15:12];
    wire [3:0]  sub      = imem_rdata[3:0];
    wire        rr       = (op == 4'h0);
    wire        basic    = (op >= 4'h1) && (op <= 4'h5);
    wire        cmp_done = instr_done && (op == 4'h3 || rr && (sub == 4'h6 || sub == 4'h7));
    wire [31:0] bra_tgt  = imem_addr + 32'h4 + {{19{imem_rdata[11]}}, imem_rdata[11:0], 1'b0};
    wire        taken    = ((op == 4'hc) == cmp_flag);
    wire [31:0] cond_nxt = taken ? imem_addr + 32'h4 + {{23{imem_rdata[7]}}, imem_rdata[7:0], 1'b0}
                                 : imem_addr + 32'h2;
    reg         first_r;
    reg         slot_r;

    // A branch sitting in a delay slot is ignored, so the slot marker must not chain.
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            first_r <= 1'b1;
            slot_r  <= 1'b0;
        end else if (instr_done) begin
            first_r <= 1'b1;
            slot_r  <= !slot_r && (op == 4'ha || op == 4'hb);
        end else begin
            first_r <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_basic_one_cycle: assert property (basic |-> instr_done)
        else $error("basic instruction did not complete in one cycle");
    a_pc_one_word: assert property (instr_done && basic && !slot_r |=> imem_addr == $past(imem_addr) + 32'h2)
        else $error("fetch address did not advance by one code word");
    a_mul_word_lat: assert property (first_r && rr && sub == 4'h8 |-> !instr_done ##1 instr_done)
        else $error("word multiply latency wrong");
    a_mac_word_lat: assert property (first_r && rr && sub == 4'h9 |-> !instr_done [*2] ##1 instr_done)
        else $error("word multiply accumulate latency wrong");
    a_mul_long_lat: assert property (LATER_GEN != 0 && first_r && rr && (sub == 4'ha || sub == 4'hb)
        |-> !instr_done [*2] ##1 instr_done)
        else $error("long multiply latency wrong");
    a_add_keeps_flag: assert property (instr_done && (op == 4'h1 || rr && sub == 4'h0) |=> $stable(cmp_flag))
        else $error("add changed the compare flag");
    a_flag_from_cmp: assert property ($changed(cmp_flag) |-> $past(cmp_done))
        else $error("compare flag changed without a compare");
    a_cond_branch: assert property (instr_done && !slot_r && (op == 4'hc || op == 4'hd)
        |=> imem_addr == $past(cond_nxt))
        else $error("conditional branch went to the wrong place");
    a_bra_slot_first: assert property (instr_done && !slot_r && op == 4'ha |=> imem_addr == $past(imem_addr) + 32'h2)
        else $error("delay slot not executed after branch");
    a_bra_target: assert property (instr_done && !slot_r && op == 4'ha ##1 instr_done
        |=> imem_addr == $past(bra_tgt, 2))
        else $error("branch target wrong after slot");
    a_mem_only_ls: assert property (dmem_re || dmem_we |-> op inside {4'h6, 4'h7, 4'h8, 4'h9, 4'he})
        else $error("memory access by a register-only instruction");
    a_literal_size: assert property (dmem_re && (op == 4'h8 || op == 4'h9)
        |-> dmem_size == ((op == 4'h8) ? 2'h1 : 2'h2))
        else $error("literal fetch size wrong");

    c_mul: cover property (first_r && rr && sub == 4'h8);
    c_taken: cover property (instr_done && op == 4'hc && cmp_flag);
    c_bitmem: cover property (dmem_we && op == 4'he);
endmodule

bind rcp_core rcp_core_chk #(.LATER_GEN(LATER_GEN)) u_chk (
    .clk_sys(clk_sys), .arst_n(arst_n), .imem_addr(imem_addr), .imem_rdata(imem_rdata),
    .dmem_addr(dmem_addr), .dmem_re(dmem_re), .dmem_we(dmem_we), .dmem_size(dmem_size),
    .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata), .cmp_flag(cmp_flag), .instr_done(instr_done)
);

// *** rcp_mem_model.sv ***
// Combined instruction and data memory facing the core, with a side port for loading images.
`timescale 1ns/100ps
module rcp_mem_model (
    input  wire        clk_sys,     // Core clock
    input  wire [31:0] imem_addr,   // Fetch address
    output wire [15:0] imem_rdata,  // Fetched word
    input  wire [31:0] dmem_addr,   // Data address
    input  wire        dmem_re,     // Read strobe
    input  wire        dmem_we,     // Write strobe
    input  wire [1:0]  dmem_size,   // Access size
    input  wire [31:0] dmem_wdata,  // Write data
    output wire [31:0] dmem_rdata,  // Read data
    input  wire        ld_en,       // Image load strobe
    input  wire [5:0]  ld_idx,      // Halfword index to load
    input  wire [15:0] ld_data      // Halfword to load
);
    reg  [15:0] mem [0:63];
    reg  [31:0] val;
    wire [5:0]  di = dmem_addr[6:1];
    wire [15:0] hw = mem[di];
    wire [7:0]  by = dmem_addr[0] ? hw[7:0] : hw[15:8];
    integer     i;

    initial begin
        for (i = 0; i < 64; i = i + 1) begin
            mem[i] = 16'hf000;
        end
    end
    // Upper bits carry junk so that a missing sign extension cannot pass by luck.
    always @* begin
        case (dmem_size)
            2'h0:    val = {24'ha5a5a5, by};
            2'h1:    val = {16'ha5a5, hw};
            default: val = {hw, mem[di + 6'h1]};
        endcase
    end
    assign imem_rdata = mem[imem_addr[6:1]];
    // With no read pending the bus shows the inverse of what a read would return.
    assign dmem_rdata = dmem_re ? val : ~val;
    // Big-endian: the even byte is the high half of a halfword.
    always @(posedge clk_sys) begin
        if (ld_en) begin
            mem[ld_idx] <= ld_data;
        end else if (dmem_we) begin
            if (dmem_size == 2'h0 && dmem_addr[0]) begin
                mem[di][7:0] <= dmem_wdata[7:0];
            end else if (dmem_size == 2'h0) begin
                mem[di][15:8] <= dmem_wdata[7:0];
            end else if (dmem_size == 2'h1) begin
                mem[di] <= dmem_wdata[15:0];
            end else begin
                mem[di] <= dmem_wdata[31:16];
                mem[di + 6'h1] <= dmem_wdata[15:0];
            end
        end
    end
endmodule

// *** rcp_core_test.sv ***
// Self-checking bench: each row runs a short program from reset and checks the first store.
`timescale 1ns/100ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin n_errors++; \
    $display("FAIL %s expected %h seen %h", nm, e, s); end end
module rcp_core_test;
    typedef struct packed {logic [63:0] prog; logic [7:0] addr; logic [31:0] data; logic flag;} rcp_row_t;
    logic        clk_sys, arst_n, ld_en, dmem_re, dmem_we, cmp_flag, instr_done;
    logic [5:0]  ld_idx;
    logic [15:0] ld_data, imem_rdata;
    logic [31:0] imem_addr, dmem_addr, dmem_wdata, dmem_rdata;
    logic [1:0]  dmem_size;
    int          n_errors, n_compared, cyc;
    rcp_row_t    rows [0:26] = '{
        '{64'h2180_f000_f000_f000, 8'h40, 32'hffffff80, 1'b0},
        '{64'h217f_11ff_f000_f000, 8'h40, 32'h0000007e, 1'b0},
        '{64'h21ff_41f0_f000_f000, 8'h40, 32'h000000f0, 1'b0},
        '{64'h2100_5180_f000_f000, 8'h40, 32'h00000080, 1'b0},
        '{64'h810d_f000_f000_f000, 8'h40, 32'hffff8001, 1'b0},
        '{64'h9108_f000_f000_f000, 8'h40, 32'h5a5a5a5a, 1'b0},
        '{64'h2322_6130_f000_f000, 8'h40, 32'hffffff80, 1'b0},
        '{64'h2322_6131_f000_f000, 8'h40, 32'hffff8080, 1'b0},
        '{64'h8011_6125_f000_f000, 8'h40, 32'hffff8080, 1'b0},
        '{64'h930a_6131_f000_f000, 8'h40, 32'hffff8080, 1'b0},
        '{64'h21ff_31ff_f000_f000, 8'h40, 32'hffffffff, 1'b1},
        '{64'h2180_0127_f000_f000, 8'h40, 32'hffffff80, 1'b0},
        '{64'h2140_0127_f000_f000, 8'h40, 32'h00000040, 1'b1},
        '{64'h2100_3100_11ff_f000, 8'h40, 32'hffffffff, 1'b1},
        '{64'h2101_3101_c000_2177, 8'h40, 32'h00000001, 1'b1},
        '{64'h2101_3101_d000_2177, 8'h40, 32'h00000077, 1'b1},
        '{64'h2101_3102_c000_2177, 8'h40, 32'h00000077, 1'b0},
        '{64'h2101_3102_d000_2177, 8'h40, 32'h00000001, 1'b0},
        '{64'h21fd_0128_012c_f000, 8'h40, 32'hffffff40, 1'b0},
        '{64'h21fe_012a_012d_f000, 8'h40, 32'hffffffff, 1'b0},
        '{64'h012e_0229_012c_f000, 8'h40, 32'h00001000, 1'b0},
        '{64'h2022_e101_f000_f000, 8'h22, 32'h00000081, 1'b0},
        '{64'h2022_e00f_f000_f000, 8'h22, 32'h00000000, 1'b0},
        '{64'h2166_a001_2155_2177, 8'h40, 32'h00000055, 1'b0},
        '{64'h2166_230a_b300_230c, 8'h40, 32'h00000066, 1'b0},
        '{64'h2180_0127_2105_3105, 8'h40, 32'h00000005, 1'b1},
        '{64'h2105_3105_f000_f000, 8'h40, 32'h00000005, 1'b1}
    };

    rcp_core dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .imem_addr(imem_addr), .imem_rdata(imem_rdata),
        .dmem_addr(dmem_addr), .dmem_re(dmem_re), .dmem_we(dmem_we), .dmem_size(dmem_size),
        .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata), .cmp_flag(cmp_flag), .instr_done(instr_done)
    );
    rcp_mem_model mem (
        .clk_sys(clk_sys), .imem_addr(imem_addr), .imem_rdata(imem_rdata), .dmem_addr(dmem_addr),
        .dmem_re(dmem_re), .dmem_we(dmem_we), .dmem_size(dmem_size), .dmem_wdata(dmem_wdata),
        .dmem_rdata(dmem_rdata), .ld_en(ld_en), .ld_idx(ld_idx), .ld_data(ld_data)
    );

    // Fixed frame: base address setup, four row words, store of R1, then a self loop with its slot.
    function automatic logic [15:0] img(input int i, input logic [63:0] p);
        case (i)
            0:       img = 16'h2240;
            1, 2, 3, 4: img = p[16 * (4 - i) +: 16];
            5:       img = 16'h7212;
            6:       img = 16'haffe;
            16:      img = 16'h8001;
            17:      img = 16'h8080;
            18, 19:  img = 16'h5a5a;
            20:      img = 16'hffe2;
            22, 23:  img = 16'h0022;
            default: img = 16'hf000;
        endcase
    endfunction

    task automatic summarize();
        if (n_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic run(input rcp_row_t r);
        int k;
        @(negedge clk_sys);
        arst_n = 1'b0;
        ld_en = 1'b1;
        for (k = 0; k < 64; k++) begin
            ld_idx = k[5:0];
            ld_data = img(k, r.prog);
            @(negedge clk_sys);
        end
        ld_en = 1'b0;
        `CHK("reset fetch address", 32'h0, imem_addr)
        `CHK("reset flag", 1'b0, cmp_flag)
        arst_n = 1'b1;
        k = 0;
        while (dmem_we !== 1'b1 && k < 60) begin
            @(negedge clk_sys);
            k++;
        end
        `CHK("store address", {24'h0, r.addr}, dmem_addr)
        `CHK("store data", r.data, dmem_wdata)
        `CHK("compare flag", r.flag, cmp_flag)
    endtask

    always #5 clk_sys = ~clk_sys;

    // Rows take about 70 cycles each; the ceiling leaves ample margin.
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            summarize();
        end
    end

    initial begin
        clk_sys = 1'b0;
        arst_n = 1'b0;
        ld_en = 1'b0;
        ld_idx = 6'h0;
        ld_data = 16'h0;
        repeat (2) @(negedge clk_sys);
        foreach (rows[i]) begin
            run(rows[i]);
        end
        // Reset in mid-run, between edges, must clear the flag and fetch address at once.
        @(negedge clk_sys);
        arst_n = 1'b0;
        #1;
        `CHK("async reset fetch address", 32'h0, imem_addr)
        `CHK("async reset flag", 1'b0, cmp_flag)
        summarize();
    end
endmodule
